// >>> shared/bst_regs.svh
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

// Opcodes and widths
`define BST_IR_W          4
`define BST_OP_EXTEST     4'h0
`define BST_OP_IDCODE     4'h1
`define BST_OP_SAMPLE     4'h2
`define BST_OP_RESET      4'hc
`define BST_OP_BYPASS     4'hf
`define BST_ID_W          32

// Register byte offsets on the bus
`define BST_ADDR_CTRL     4'h0
`define BST_ADDR_CAUSE    4'h4
`define BST_ADDR_IOCTL    4'h8

// Field positions
`define BST_CTRL_DIS_BIT  7
`define BST_CTRL_PUD_BIT  4
`define BST_CAUSE_FLAG    4

// Double-write window in system cycles
`define BST_DIS_WINDOW    3'd4

// Start-up hold after the test reset releases
`define BST_STARTUP_NS    1000
`define BST_CLK_NS        50
`define BST_STARTUP_CYC   ((`BST_STARTUP_NS + `BST_CLK_NS - 1) / `BST_CLK_NS)

`endif

// >>> shared/bst_pkg.sv
package bst_pkg;

    // TAP controller states, binary codes written out
    typedef enum logic [3:0] {
        TEST_RESET = 4'h0, RUN_IDLE   = 4'h1, SEL_DR    = 4'h2,
        CAP_DR     = 4'h3, SHIFT_DR   = 4'h4, EXIT1_DR  = 4'h5,
        PAUSE_DR   = 4'h6, EXIT2_DR   = 4'h7, UPD_DR    = 4'h8,
        SEL_IR     = 4'h9, CAP_IR     = 4'ha, SHIFT_IR  = 4'hb,
        EXIT1_IR   = 4'hc, PAUSE_IR   = 4'hd, EXIT2_IR  = 4'he,
        UPD_IR     = 4'hf
    } bst_tap_type;

    // Test port pins after synchronisation
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bst_tap_in_type;

    // Wishbone classic request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [3:0]  adr;
        logic [31:0] dat;
    } bst_wb_req_type;

endpackage

// >>> design/bst_tap.sv
`timescale 1ns/1ps
`include "bst_regs.svh"
// Operation
// - Bypass is one stage, cleared to zero on leaving Capture-DR.
// - Identification holds a 4-bit version, first revision zero.
// - Identification holds a 16-bit part number from a parameter.
// - Identification holds an 11-bit maker code from a parameter.
// - A one in the reset register holds the chip in reset at once.
// - After release, reset stays for the start-up time-out.
// - Instruction register is four bits, sixteen opcodes.
// - All scan registers shift least significant bit first.
// - Opcode 0x0 selects chain; latched outputs drive pins immediately.
// - External test captures pins, shifts, updates outputs.
// - Opcode 0x1 selects the 32-bit identification, default after reset.
// - Opcode 0x2 samples pins; update loads latches only.
// - Opcode 0xC selects reset register; never resets the TAP.
// - Opcode 0xF selects bypass; capture loads zero.
// - Chip reset from the reset register tri-states the port pins, except under external test.
// - Port-disable bit seven zero with fuse enables the port.
// - Port-disable changes only on a double write within four cycles.
// - Reset-cause flag bit four sets on test reset, clears by writing it zero.
// - Pull-ups forced off under external test or sample.
// - Pin cell folds control, data, input into two stages, raw input.
// - Data to port bit, control to direction; pull-up per formula.
// - Clock never driven out nor sampled under external test or sample.
// - Test clock is sampled by clk_sys, so it must run well below that clock.
module bst_tap
    import bst_pkg::*;
#(
    parameter int          NPINS    = 8,
    parameter logic [3:0]  VERSION  = 4'h0,    // Silicon revision
    parameter logic [15:0] PART_NUM = 16'h1234, // Arbitrary value
    parameter logic [10:0] MAKER_ID = 11'h055,  // Arbitrary value
    parameter int          STARTUP  = `BST_STARTUP_CYC
)(
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             tckPin,
    input  wire logic             tmsPin,
    input  wire logic             tdiPin,
    output logic                  tdoPin,
    output logic                  tdoOe,
    input  wire logic             testPortEnableFuse,
    input  wire logic             clockOutputFuse,
    input  wire logic             sysClockOut,
    input  wire logic [NPINS-1:0] padIn,
    output logic      [NPINS-1:0] padOut,
    output logic      [NPINS-1:0] padOe,
    output logic      [NPINS-1:0] pullupEn,
    output logic                  clkPadOut,
    output logic                  chipReset,
    output logic                  testPortActive,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [3:0]       wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o
);

    localparam int CW = 2 * NPINS;
    localparam int SW = $clog2(STARTUP + 1);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] syncA_q, syncB_q;
    logic       tckOld_q;
    bst_tap_in_type tapIn;
    logic       tckRise, tckFall;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            syncA_q  <= 3'h0;
            syncB_q  <= 3'h0;
            tckOld_q <= 1'b0;
        end else begin
            syncA_q  <= {tckPin, tmsPin, tdiPin};
            syncB_q  <= syncA_q;
            tckOld_q <= syncB_q[2];
        end
    end

    // Edges of the test clock; it must stay below a quarter of clk_sys
    assign tapIn   = bst_tap_in_type'(syncB_q);
    assign tckRise = tapIn.tck & ~tckOld_q;
    assign tckFall = ~tapIn.tck & tckOld_q;

    // ------------------------------------------------------------
    // TAP controller
    // ------------------------------------------------------------
    bst_tap_type state_q, state_d;

    always_comb begin
        state_d = state_q;
        if (tckRise) begin
            unique case (state_q)
                TEST_RESET: state_d = tapIn.tms ? TEST_RESET : RUN_IDLE;
                RUN_IDLE:   state_d = tapIn.tms ? SEL_DR : RUN_IDLE;
                SEL_DR:     state_d = tapIn.tms ? SEL_IR : CAP_DR;
                CAP_DR:     state_d = tapIn.tms ? EXIT1_DR : SHIFT_DR;
                SHIFT_DR:   state_d = tapIn.tms ? EXIT1_DR : SHIFT_DR;
                EXIT1_DR:   state_d = tapIn.tms ? UPD_DR : PAUSE_DR;
                PAUSE_DR:   state_d = tapIn.tms ? EXIT2_DR : PAUSE_DR;
                EXIT2_DR:   state_d = tapIn.tms ? UPD_DR : SHIFT_DR;
                UPD_DR:     state_d = tapIn.tms ? SEL_DR : RUN_IDLE;
                SEL_IR:     state_d = tapIn.tms ? TEST_RESET : CAP_IR;
                CAP_IR:     state_d = tapIn.tms ? EXIT1_IR : SHIFT_IR;
                SHIFT_IR:   state_d = tapIn.tms ? EXIT1_IR : SHIFT_IR;
                EXIT1_IR:   state_d = tapIn.tms ? UPD_IR : PAUSE_IR;
                PAUSE_IR:   state_d = tapIn.tms ? EXIT2_IR : PAUSE_IR;
                EXIT2_IR:   state_d = tapIn.tms ? UPD_IR : SHIFT_IR;
                UPD_IR:     state_d = tapIn.tms ? SEL_DR : RUN_IDLE;
            endcase
        end
        if (!testPortActive)
            state_d = TEST_RESET;
    end

    // Only the power-on reset and an inactive port (fuse low or disable bit set) touch the TAP
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            state_q <= TEST_RESET;
        else
            state_q <= state_d;
    end

    // ------------------------------------------------------------
    // Instruction and data registers
    // ------------------------------------------------------------
    logic [`BST_IR_W-1:0]  irShift_q, irShift_d, ir_q, ir_d;
    logic [`BST_ID_W-1:0]  drShift_q, drShift_d;
    logic [CW-1:0]         chain_q, chain_d, latch_q, latch_d;
    logic                  bypass_q, bypass_d, rstReg_q, rstReg_d;
    logic                  tdo_q, tdo_d, tdoOe_q, tdoOe_d;
    logic [CW-1:0]         capVec;
    logic [`BST_ID_W-1:0]  idWord;
    logic                  chainSel, pinDrive;

    assign idWord   = {VERSION, PART_NUM, MAKER_ID, 1'b1};
    assign chainSel = (ir_q == `BST_OP_EXTEST) ||
                      (ir_q == `BST_OP_SAMPLE);
    assign pinDrive = (ir_q == `BST_OP_EXTEST);

    // Each cell: even bit is control, odd bit is data; raw pad input
    // replaces the data stage on capture (no synchroniser).
    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : gCell
            assign capVec[2*g]   = padOe[g];
            assign capVec[2*g+1] = padIn[g];
        end
    endgenerate

    always_comb begin
        irShift_d = irShift_q;
        ir_d      = ir_q;
        drShift_d = drShift_q;
        chain_d   = chain_q;
        latch_d   = latch_q;
        bypass_d  = bypass_q;
        rstReg_d  = rstReg_q;
        tdo_d     = tdo_q;
        tdoOe_d   = tdoOe_q;
        if (tckRise) begin
            unique case (state_q)
                TEST_RESET: ir_d = `BST_OP_IDCODE;
                CAP_IR:     irShift_d = 4'h1;
                SHIFT_IR:   irShift_d = {tapIn.tdi, irShift_q[3:1]};
                CAP_DR: begin
                    if (chainSel)
                        chain_d = capVec;
                    if (ir_q == `BST_OP_IDCODE)
                        drShift_d = idWord;
                    bypass_d = 1'b0;
                end
                SHIFT_DR: begin
                    unique case (ir_q)
                        `BST_OP_EXTEST, `BST_OP_SAMPLE:
                            chain_d = {tapIn.tdi, chain_q[CW-1:1]};
                        `BST_OP_IDCODE:
                            drShift_d = {tapIn.tdi, drShift_q[31:1]};
                        `BST_OP_RESET:
                            rstReg_d = tapIn.tdi;
                        default:
                            bypass_d = tapIn.tdi;
                    endcase
                end
                UPD_DR:
                    if (chainSel)
                        latch_d = chain_q;
                UPD_IR:     ir_d = irShift_q;
                default: ;
            endcase
        end
        // TDO changes on the falling test clock edge
        if (tckFall) begin
            tdoOe_d = (state_q == SHIFT_DR) || (state_q == SHIFT_IR);
            if (state_q == SHIFT_IR)
                tdo_d = irShift_q[0];
            else
                unique case (ir_q)
                    `BST_OP_EXTEST, `BST_OP_SAMPLE: tdo_d = chain_q[0];
                    `BST_OP_IDCODE: tdo_d = drShift_q[0];
                    `BST_OP_RESET:  tdo_d = rstReg_q;
                    default:        tdo_d = bypass_q;
                endcase
        end
        if (!testPortActive) begin
            ir_d    = `BST_OP_IDCODE;
            tdoOe_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irShift_q <= 4'h1;
            ir_q      <= `BST_OP_IDCODE;
            drShift_q <= 32'h0;
            chain_q   <= '0;
            latch_q   <= '0;
            bypass_q  <= 1'b0;
            rstReg_q  <= 1'b0;
            tdo_q     <= 1'b0;
            tdoOe_q   <= 1'b0;
        end else begin
            irShift_q <= irShift_d;
            ir_q      <= ir_d;
            drShift_q <= drShift_d;
            chain_q   <= chain_d;
            latch_q   <= latch_d;
            bypass_q  <= bypass_d;
            rstReg_q  <= rstReg_d;
            tdo_q     <= tdo_d;
            tdoOe_q   <= tdoOe_d;
        end
    end

    // ------------------------------------------------------------
    // Chip reset and start-up hold
    // ------------------------------------------------------------
    logic [SW-1:0] hold_q, hold_d;
    logic          chipRst_q, chipRst_d;

    // Reset follows the register level combinationally in clk_sys
    // terms, so it asserts in the same cycle the bit is shifted in.
    always_comb begin
        hold_d = hold_q;
        if (rstReg_d)
            hold_d = SW'(STARTUP);
        else if (hold_q != '0)
            hold_d = hold_q - 1'b1;
        // Loaded count is read a cycle later, so the full hold is kept
        chipRst_d = rstReg_d || (hold_q != '0);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hold_q    <= '0;
            chipRst_q <= 1'b0;
        end else begin
            hold_q    <= hold_d;
            chipRst_q <= chipRst_d;
        end
    end

    // ------------------------------------------------------------
    // Wishbone registers
    // ------------------------------------------------------------
    logic       portDis_q, portDis_d, pendVal_q, pendVal_d;
    logic [2:0] winCnt_q, winCnt_d;
    logic       flag_q, flag_d, pud_q, pud_d;
    logic [NPINS-1:0] portBit_q, portBit_d, dirBit_q, dirBit_d;
    logic [31:0] rdat_q, rdat_d;
    logic        ack_q, ack_d;
    logic        wbReq, wbWr, lane0;

    assign wbReq = wb_cyc_i && wb_stb_i && !ack_q;
    assign wbWr  = wbReq && wb_we_i;
    assign lane0 = wb_sel_i[0];

    always_comb begin
        portDis_d = portDis_q;
        pendVal_d = pendVal_q;
        winCnt_d  = (winCnt_q != 3'd0) ? winCnt_q - 3'd1 : 3'd0;
        flag_d    = flag_q;
        pud_d     = pud_q;
        portBit_d = portBit_q;
        dirBit_d  = dirBit_q;
        rdat_d    = 32'h0;
        ack_d     = wbReq;
        if (wbWr && lane0) begin
            unique case (wb_adr_i)
                `BST_ADDR_CTRL: begin
                    pud_d = wb_dat_i[`BST_CTRL_PUD_BIT];
                    if (winCnt_q != 3'd0 &&
                        pendVal_q == wb_dat_i[`BST_CTRL_DIS_BIT]) begin
                        portDis_d = pendVal_q;
                        winCnt_d  = 3'd0;
                    end else begin
                        pendVal_d = wb_dat_i[`BST_CTRL_DIS_BIT];
                        winCnt_d  = `BST_DIS_WINDOW;
                    end
                end
                `BST_ADDR_CAUSE:
                    if (!wb_dat_i[`BST_CAUSE_FLAG])
                        flag_d = 1'b0;
                `BST_ADDR_IOCTL: begin
                    portBit_d = wb_dat_i[NPINS-1:0];
                    dirBit_d  = wb_dat_i[16+NPINS-1:16];
                end
                default: ;
            endcase
        end
        // Set wins over a software clear in the same cycle
        if (rstReg_q)
            flag_d = 1'b1;
        if (wbReq && !wb_we_i) begin
            unique case (wb_adr_i)
                `BST_ADDR_CTRL: begin
                    rdat_d[`BST_CTRL_DIS_BIT] = portDis_q;
                    rdat_d[`BST_CTRL_PUD_BIT] = pud_q;
                end
                `BST_ADDR_CAUSE: rdat_d[`BST_CAUSE_FLAG] = flag_q;
                `BST_ADDR_IOCTL: begin
                    rdat_d[NPINS-1:0]     = portBit_q;
                    rdat_d[16+NPINS-1:16] = dirBit_q;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            portDis_q <= 1'b0;
            pendVal_q <= 1'b0;
            winCnt_q  <= 3'd0;
            flag_q    <= 1'b0;
            pud_q     <= 1'b0;
            portBit_q <= '0;
            dirBit_q  <= '0;
            rdat_q    <= 32'h0;
            ack_q     <= 1'b0;
        end else begin
            portDis_q <= portDis_d;
            pendVal_q <= pendVal_d;
            winCnt_q  <= winCnt_d;
            flag_q    <= flag_d;
            pud_q     <= pud_d;
            portBit_q <= portBit_d;
            dirBit_q  <= dirBit_d;
            rdat_q    <= rdat_d;
            ack_q     <= ack_d;
        end
    end

    // ------------------------------------------------------------
    // Pad outputs, all registered
    // ------------------------------------------------------------
    logic [NPINS-1:0] padOut_q, padOut_d, padOe_q, padOe_d;
    logic [NPINS-1:0] pull_q, pull_d;
    logic             clkOut_q, clkOut_d, act_q, act_d;

    always_comb begin
        act_d = testPortEnableFuse && !portDis_q;
        for (int i = 0; i < NPINS; i++) begin
            if (pinDrive) begin
                padOut_d[i] = latch_q[2*i+1];
                padOe_d[i]  = latch_q[2*i];
            end else begin
                padOut_d[i] = portBit_q[i];
                padOe_d[i]  = dirBit_q[i];
            end
        end
        // Pull-up per port formula, forced off during scan
        pull_d = ~{NPINS{pud_q}} & ~dirBit_q & portBit_q;
        if (chainSel)
            pull_d = '0;
        // Chip reset floats the port pins and drops pull-ups, unless pinDrive is set
        if (chipRst_q && !pinDrive) begin
            padOe_d = '0;
            pull_d  = '0;
        end
        clkOut_d = clockOutputFuse && sysClockOut && !chainSel;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            padOut_q <= '0;
            padOe_q  <= '0;
            pull_q   <= '0;
            clkOut_q <= 1'b0;
            act_q    <= 1'b0;
        end else begin
            padOut_q <= padOut_d;
            padOe_q  <= padOe_d;
            pull_q   <= pull_d;
            clkOut_q <= clkOut_d;
            act_q    <= act_d;
        end
    end

    assign padOut         = padOut_q;
    assign padOe          = padOe_q;
    assign pullupEn       = pull_q;
    assign clkPadOut      = clkOut_q;
    assign chipReset      = chipRst_q;
    assign testPortActive = act_q;
    assign tdoPin         = tdo_q;
    assign tdoOe          = tdoOe_q;
    assign wb_dat_o       = rdat_q;
    assign wb_ack_o       = ack_q;

endmodule

// >>> testbench/bst_chk_properties.sv
`timescale 1ns/1ps
module bst_chk_properties #(
    parameter int STARTUP = 4
)(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic testPortEnableFuse,
    input wire logic testPortActive,
    input wire logic clockOutputFuse,
    input wire logic clkPadOut,
    input wire logic chipReset,
    input wire logic tdoOe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // -----------------
    // Reset hold count
    // -----------------
    // Saturates so a long test reset cannot wrap to a false short
    logic [7:0] hiCnt_q;
    logic [7:0] hiCnt_d;
    always_comb begin
        hiCnt_d = !chipReset ? 8'h00 : (&hiCnt_q ? hiCnt_q : hiCnt_q + 8'h01);
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) hiCnt_q <= 8'h00;
        else hiCnt_q <= hiCnt_d;
    end
    // -----------------
    // Properties
    // -----------------
    a_ack_next: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held too long");
    a_ack_cause: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("bus ack without request");
    a_port_off: assert property (
        !testPortEnableFuse |=> !testPortActive)
        else $error("test port active without fuse");
    a_port_fuse: assert property (
        $rose(testPortActive) |-> $past(testPortEnableFuse))
        else $error("test port enabled while fuse low");
    a_tdo_quiet: assert property (
        !testPortEnableFuse |-> ##[1:4] !tdoOe)
        else $error("serial out driven by disabled port");
    a_clk_gate: assert property (!clockOutputFuse |=> !clkPadOut)
        else $error("clock driven out without fuse");
    a_startup_hold: assert property (
        $fell(chipReset) |-> hiCnt_q >= STARTUP)
        else $error("chip reset released before start-up time");
endmodule

bind bst_tap bst_chk_properties #(.STARTUP(STARTUP)) chk_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .testPortEnableFuse(testPortEnableFuse),
    .testPortActive(testPortActive), .clockOutputFuse(clockOutputFuse),
    .clkPadOut(clkPadOut), .chipReset(chipReset), .tdoOe(tdoOe)
);

// >>> testbench/bst_host.sv
`timescale 1ns/1ps
module bst_host (
    input  wire logic clk_sys,
    input  wire logic tdoPin,
    output logic      tckPin,
    output logic      tmsPin,
    output logic      tdiPin
);
    // Test clock idles low between frames, paced off clk_sys
    initial begin
        tckPin = 1'b0;
        tmsPin = 1'b1;
        tdiPin = 1'b0;
    end
    // One 400 ns period; serial out read just before the rise
    task automatic tick(input logic m, input logic d, output logic o);
        tmsPin <= m;
        tdiPin <= d;
        repeat (3) @(posedge clk_sys);
        o = tdoPin;
        tckPin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        tckPin <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    // Idle to shift, n bits low bit first, back to idle
    task automatic scan(input bit ir, input int n,
                        input logic [63:0] din, output logic [63:0] dout);
        logic o;
        dout = '0;
        tick(1'b1, 1'b0, o);
        if (ir) tick(1'b1, 1'b0, o);
        repeat (2) tick(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
    endtask
    // Five highs reach Test-Logic-Reset from anywhere
    task automatic reset_tap();
        logic o;
        repeat (5) tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
    endtask
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import bst_pkg::*;
    localparam int          NP    = 8;
    localparam logic [15:0] PART  = 16'h5a3c; // Arbitrary value
    localparam logic [10:0] MAKER = 11'h2b1;  // Arbitrary value
    localparam logic [31:0] ID    = {4'h0, PART, MAKER, 1'b1};
    logic           clk_sys = 1'b0;
    logic           rst_n = 1'b0;
    logic           sysClk = 1'b0;
    logic           fuseEn = 1'b1;
    logic           fuseClk = 1'b0;
    logic [NP-1:0]  padIn = '0;
    bst_wb_req_type req = '0;
    logic           tck, tms, tdi, tdo, tdoOe, clkPad, chipReset, active, ack;
    logic [NP-1:0]  padOut, padOe, pullupEn;
    logic [31:0]    wbDat, rd;
    logic [63:0]    dq, pre;
    int             nMismatch = 0;
    int             checkCount = 0;
    int             cycles = 0;
    int             bq[$];
    time            tckT = 0, relT = 0;

    always #25 clk_sys = ~clk_sys;
    // Time from a test clock rise to the chip reset release
    always @(posedge tck) tckT = $time;
    always @(negedge chipReset) relT = $time - tckT;
    // Chip clock stand-in, and a ceiling on the whole run
    always @(posedge clk_sys) begin
        sysClk <= ~sysClk;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nMismatch++;
            testDone();
        end
    end

    bst_tap #(.NPINS(NP), .PART_NUM(PART), .MAKER_ID(MAKER), .STARTUP(4))
    dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .tckPin(tck), .tmsPin(tms),
        .tdiPin(tdi), .tdoPin(tdo), .tdoOe(tdoOe), .sysClockOut(sysClk),
        .testPortEnableFuse(fuseEn), .clockOutputFuse(fuseClk),
        .padIn(padIn), .padOut(padOut), .padOe(padOe), .pullupEn(pullupEn),
        .clkPadOut(clkPad), .chipReset(chipReset), .testPortActive(active),
        .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
        .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat),
        .wb_dat_o(wbDat), .wb_ack_o(ack));
    bst_host host_u (.clk_sys(clk_sys), .tdoPin(tdo), .tckPin(tck),
        .tmsPin(tms), .tdiPin(tdi));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Classic cycle held until ack is seen, then a cycle of rest
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
        do begin
            @(posedge clk_sys);
        end while (ack !== 1'b1);
        rd = wbDat;
        req <= '0;
        @(posedge clk_sys);
    endtask
    function automatic logic [7:0] half(input logic [63:0] v, input int o);
        for (int i = 0; i < NP; i++) half[i] = v[2 * i + o];
    endfunction
    task automatic tend(input string s);
        $display("test %0s finished", s);
    endtask
    task automatic testDone();
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        void'($urandom(32'h19583e0a));
        repeat (3) @(posedge clk_sys);
        // Reset values, the unmapped word included
        for (int a = 0; a < 16; a += 4) begin
            wb(4'(a), 1'b0, 32'h0);
            chk(64'(rd), 64'h0);
        end
        chk(64'(active), 64'h1);
        tend("reset values");
        host_u.reset_tap();
        host_u.scan(1'b0, 32, 64'h0, dq);
        chk(dq, 64'(ID));
        tend("idcode");
        // Bypass: captured zero leads, data one stage behind
        host_u.scan(1'b1, 4, 64'hf, dq);
        pre = 64'($urandom);
        bq = {0};
        host_u.scan(1'b0, 8, pre, dq);
        for (int i = 0; i < 8; i++) begin
            bq.push_back(int'(pre[i]));
            chk(64'(dq[i]), 64'(bq.pop_front()));
        end
        tend("bypass");
        // Direction 0f, port ff: pull-ups only on the input half
        wb(4'h8, 1'b1, 32'h000f00ff);
        wb(4'h8, 1'b0, 32'h0);
        chk(64'(rd), 64'h000f00ff);
        chk(64'({padOe, padOut, pullupEn}), 64'h0ffff0);
        wb(4'h0, 1'b1, 32'h10);
        chk(64'(pullupEn), 64'h0);
        wb(4'h0, 1'b1, 32'h0);
        padIn <= 8'($urandom);
        host_u.scan(1'b1, 4, 64'h2, dq);
        chk(64'({padOe, padOut, pullupEn}), 64'h0fff00);
        pre = 64'($urandom);
        host_u.scan(1'b0, 2 * NP, pre, dq);
        chk(64'(half(dq, 1)), 64'(padIn));
        chk(64'({padOe, padOut}), 64'h0fff);
        tend("sample");
        // Preloaded latches reach the pins as the opcode lands
        fuseClk <= 1'b1;
        host_u.scan(1'b1, 4, 64'h0, dq);
        chk(64'({padOe, padOut}), 64'({half(pre, 0), half(pre, 1)}));
        repeat (4) begin
            @(posedge clk_sys);
            chk(64'(clkPad), 64'h0);
        end
        padIn <= 8'($urandom);
        pre = 64'($urandom);
        host_u.scan(1'b0, 2 * NP, pre, dq);
        chk(64'(half(dq, 1)), 64'(padIn));
        chk(64'({padOe, padOut}), 64'({half(pre, 0), half(pre, 1)}));
        tend("extest");
        // Reset register holds the chip but leaves the TAP alone
        host_u.scan(1'b1, 4, 64'hc, dq);
        host_u.scan(1'b0, 1, 64'h1, dq);
        chk(64'({chipReset, padOe}), 64'h100);
        host_u.scan(1'b0, 1, 64'h0, dq);
        chk(dq, 64'h1);
        for (int k = 0; k < 200 && chipReset !== 1'b0; k++) @(posedge clk_sys);
        chk(64'(chipReset), 64'h0);
        // Edge seen three cycles after the pin, then four hold cycles
        chk(64'(relT / 50), 64'(3 + 4));
        wb(4'h4, 1'b0, 32'h0);
        chk(64'(rd), 64'h10);
        wb(4'h4, 1'b1, 32'h0);
        wb(4'h4, 1'b0, 32'h0);
        chk(64'(rd), 64'h0);
        tend("reset register");
        // A lone write must not move the disable bit
        wb(4'h0, 1'b1, 32'h80);
        repeat (8) @(posedge clk_sys);
        chk(64'(active), 64'h1);
        wb(4'h0, 1'b1, 32'h80);
        wb(4'h0, 1'b1, 32'h80);
        @(posedge clk_sys);
        chk(64'(active), 64'h0);
        wb(4'h0, 1'b0, 32'h0);
        chk(64'(rd), 64'h80);
        wb(4'h0, 1'b1, 32'h0);
        wb(4'h0, 1'b1, 32'h0);
        @(posedge clk_sys);
        chk(64'(active), 64'h1);
        fuseEn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(64'(active), 64'h0);
        fuseEn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        host_u.reset_tap();
        host_u.scan(1'b0, 32, 64'h0, dq);
        chk(dq, 64'(ID));
        tend("port disable");
        testDone();
    end
endmodule
